// file: pkg/lsmc_regs.svh
// Constants and timing counts of the serial LED sink mode control block.
//
// What this block does
// (RULE_01) Normal mode shifts serial data to output.
// (RULE_02) Normal-mode strobe high loads output latch.
// (RULE_03) Sinks on only while enable low.
// (RULE_04) One shared 8-bit shift register.
// (RULE_05) Power on starts in normal mode.
// (RULE_06) Enable pattern 101 starts mode switching.
// (RULE_07) Strobe at fourth edge picks mode.
// (RULE_08) Strobe loads nothing during edges three-five.
// (RULE_09) Short enable pulse still turns sinks on; code misses a low pulse that falls between two system clock edges.
// (RULE_10) Shifting continues through mode switching.
// (RULE_11) Mode strobe sampled on rising edge.
// (RULE_12) Entering normal mode clears error status.
// (RULE_13) Special mode, enable high: plain shifting.
// (RULE_14) Special mode, enable low: sinks on, detect.
// (RULE_15) After second low, source becomes status.
// (RULE_16) Third later lows load status; 2 us settle.
// (RULE_17) Enable high restores serial source, sinks off.
// (RULE_18) Special mode: shifting and detection exclusive.
// (RULE_19) Special-mode strobe loads configuration latch.
// (RULE_20) Configuration kept until rewritten or reset.
// (RULE_21) Controller orders readout and configuration writes.
// (RULE_22) Configuration defaults to high multiplier, 127/128.
// (RULE_23) Config bits: multiplier, range, six mantissa.
// (RULE_24) Status bit 1 good, 0 fault or off.
// (RULE_25) Status sticky until return to normal mode.
// (RULE_26) Output latch follows while strobe high.
`ifndef LSMC_REGS_SVH
`define LSMC_REGS_SVH

`define LSMC_CH_NUM 8
`define LSMC_SR_W 8
`define LSMC_CFG_RESET 8'hff
`define LSMC_OUT_RESET 8'h00
`define LSMC_ERR_RESET 8'hff
`define LSMC_CFG_CM_BIT 0
`define LSMC_CFG_HC_BIT 1
`define LSMC_CFG_MANT_LSB 2
`define LSMC_CFG_MANT_W 6
`define LSMC_LOWS_TO_LOAD 2'h2
`define LSMC_SYS_CLK_KHZ 10000
`define LSMC_SETTLE_NS 2000
`define LSMC_SETTLE_CYC ((`LSMC_SETTLE_NS * `LSMC_SYS_CLK_KHZ + 999999) / 1000000)

`endif

// file: pkg/lsmc_pkg.sv
// Types shared by the serial LED sink mode control block.
package lsmc_pkg;

    typedef enum logic [1:0] {
        lsmc_st_normal = 2'b00,
        lsmc_st_decide = 2'b01,
        lsmc_st_settle = 2'b10,
        lsmc_st_special = 2'b11
    } lsmc_mode_t;

    typedef enum logic {
        lsmc_src_serial = 1'b0,
        lsmc_src_status = 1'b1
    } lsmc_src_t;

endpackage : lsmc_pkg

// file: pkg/lsmc_word_if.sv
// Word hand-off carrier between the control logic and a clock crossing.
`timescale 1ns/1ps
interface lsmc_word_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic load;

    modport src (output data, output load);
    modport dst (input data, input load);
endinterface : lsmc_word_if

// file: verilog/lsmc_xfer.sv
// Toggle-handshake word crossing from one clock domain to another.
`timescale 1ns/1ps
module lsmc_xfer #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic src_clk_in,
    input wire logic dst_clk_in,
    input wire logic rstn_in,
    lsmc_word_if.dst word_if,
    output logic [W-1:0] data_out
);

    logic [W-1:0] hold_q;
    logic req_q;
    logic pend_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic ack_q;
    logic busy;

    ////////////////////////////////////////////////////////////////////////
    // Source side. The hold word stays still while a transfer is open.
    assign busy = req_q != ack_s2_q;

    always_ff @(posedge src_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_q <= RST;
            req_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (!busy && (word_if.load || pend_q)) begin
            // A load seen while busy is replayed with the newest word.
            hold_q <= word_if.data;
            req_q <= ~req_q;
            pend_q <= 1'b0;
        end else if (word_if.load) begin
            pend_q <= 1'b1;
        end
    end

    always_ff @(posedge src_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Destination side.
    always_ff @(posedge dst_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_q <= 1'b0;
            data_out <= RST;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            if (req_s2_q != req_s3_q) begin
                data_out <= hold_q;
                ack_q <= req_s2_q;
            end
        end
    end

endmodule : lsmc_xfer

// file: verilog/lsmc_top.sv
// Serial control logic of an eight-channel LED sink driver.
`timescale 1ns/1ps
`include "lsmc_regs.svh"
module lsmc_top #(
    parameter int CH = `LSMC_CH_NUM,
    parameter int SETTLE_CYC = `LSMC_SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_pin_in,
    input wire logic latch_strobe_line_in,
    input wire logic output_enable_n_line_in,
    input wire logic [CH-1:0] channel_fault_in,
    output logic serial_out_pin_out,
    output logic [CH-1:0] channel_sink_out,
    output logic current_multiplier_bit_out,
    output logic gain_range_bit_out,
    output logic [`LSMC_CFG_MANT_W-1:0] gain_mantissa_out,
    output logic special_mode_out,
    output logic error_detect_out
);

    localparam int SR = `LSMC_SR_W;

    ////////////////////////////////////////////////////////////////////////
    // Link-domain signals. The serial pins are already synchronous to the
    // serial clock, so they are sampled without synchronisers.
    lsmc_pkg::lsmc_mode_t state_q;
    lsmc_pkg::lsmc_mode_t state_d;
    lsmc_pkg::lsmc_src_t src;
    logic [1:0] oe_hist_q;
    logic pulse_det;
    logic sel_special_q;
    logic clr_tgl_q;
    logic special_lvl_q;
    logic [1:0] low_cnt_q;
    logic [SR-1:0] shift_q;
    logic [SR-1:0] shift_d;
    logic [SR-1:0] out_latch_q;
    logic [SR-1:0] cfg_q;
    logic [SR-1:0] status_link;
    logic strobe_ok;
    logic out_wr_q;
    logic cfg_wr_q;
    logic in_normal;
    logic in_special;

    ////////////////////////////////////////////////////////////////////////
    // System-domain signals.
    logic oe_s1_q;
    logic oe_s2_q;
    logic mode_s1_q;
    logic mode_s2_q;
    logic clr_s1_q;
    logic clr_s2_q;
    logic clr_s3_q;
    logic clr_evt;
    logic [CH-1:0] fault_s1_q;
    logic [CH-1:0] fault_s2_q;
    logic [CH-1:0] err_ok_q;
    logic [CH-1:0] status_code;
    logic [SR-1:0] out_sys;
    logic [SR-1:0] cfg_sys;
    logic detecting;
    logic settled;
    logic [$clog2(SETTLE_CYC+1)-1:0] settle_cnt_q;

    lsmc_word_if #(.W(SR)) out_if ();
    lsmc_word_if #(.W(SR)) cfg_if ();
    lsmc_word_if #(.W(SR)) sts_if ();

    ////////////////////////////////////////////////////////////////////////
    // Mode switching on the serial clock.
    assign in_normal = state_q == lsmc_pkg::lsmc_st_normal;
    assign in_special = state_q == lsmc_pkg::lsmc_st_special;

    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oe_hist_q <= 2'h3;
        end else begin
            oe_hist_q <= {oe_hist_q[0], output_enable_n_line_in};
        end
    end

    // High, low, high on three successive edges: a pulse one clock wide.
    assign pulse_det = output_enable_n_line_in && !oe_hist_q[0] && oe_hist_q[1]
        && (in_normal || in_special); // [RULE_06]

    always_comb begin
        state_d = state_q;
        case (state_q)
            lsmc_pkg::lsmc_st_normal: begin
                if (pulse_det) begin
                    state_d = lsmc_pkg::lsmc_st_decide; // [RULE_06]
                end
            end
            lsmc_pkg::lsmc_st_special: begin
                if (pulse_det) begin
                    state_d = lsmc_pkg::lsmc_st_decide; // [RULE_06]
                end
            end
            lsmc_pkg::lsmc_st_decide: begin
                state_d = lsmc_pkg::lsmc_st_settle;
            end
            lsmc_pkg::lsmc_st_settle: begin
                state_d = sel_special_q ? lsmc_pkg::lsmc_st_special
                                        : lsmc_pkg::lsmc_st_normal;
            end
            default: begin
                state_d = lsmc_pkg::lsmc_st_normal;
            end
        endcase
    end

    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= lsmc_pkg::lsmc_st_normal; // [RULE_05]
        end else begin
            state_q <= state_d;
        end
    end

    // The strobe level at the fourth edge alone picks the next mode.
    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sel_special_q <= 1'b0;
        end else if (state_q == lsmc_pkg::lsmc_st_decide) begin
            sel_special_q <= latch_strobe_line_in; // [RULE_07] [RULE_11]
        end
    end

    // Every landing in normal mode wipes the stored error status.
    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clr_tgl_q <= 1'b0;
        end else if (state_q == lsmc_pkg::lsmc_st_settle && !sel_special_q) begin
            clr_tgl_q <= ~clr_tgl_q; // [RULE_12] [RULE_25]
        end
    end

    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            special_lvl_q <= 1'b0;
        end else begin
            special_lvl_q <= state_d == lsmc_pkg::lsmc_st_special;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift register and its input source.
    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_cnt_q <= 2'h0;
        end else if (in_special && !output_enable_n_line_in) begin
            if (low_cnt_q != 2'h3) begin
                low_cnt_q <= low_cnt_q + 2'h1;
            end
        end else begin
            low_cnt_q <= 2'h0;
        end
    end

    // In special mode, once two low samples have been seen, the next low edges take the
    // status word instead of serial data, so nothing is shifted in.
    always_comb begin
        src = lsmc_pkg::lsmc_src_serial; // [RULE_13] [RULE_17]
        if (in_special && !output_enable_n_line_in
            && low_cnt_q >= `LSMC_LOWS_TO_LOAD) begin
            src = lsmc_pkg::lsmc_src_status; // [RULE_15] [RULE_16] [RULE_18]
        end
    end

    always_comb begin
        case (src)
            lsmc_pkg::lsmc_src_status: shift_d = status_link; // [RULE_16]
            default: shift_d = {shift_q[SR-2:0], serial_in_pin_in}; // [RULE_01] [RULE_10]
        endcase
    end

    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_d; // [RULE_04]
        end
    end

    assign serial_out_pin_out = shift_q[SR-1]; // [RULE_01]

    ////////////////////////////////////////////////////////////////////////
    // Latches. The strobe is blind from the detecting edge to the edge
    // that ends mode switching.
    assign strobe_ok = latch_strobe_line_in && !pulse_det
        && (in_normal || in_special); // [RULE_08]

    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            out_latch_q <= `LSMC_OUT_RESET;
            out_wr_q <= 1'b0;
        end else begin
            out_wr_q <= strobe_ok && in_normal;
            if (strobe_ok && in_normal) begin
                out_latch_q <= shift_d; // [RULE_02] [RULE_26]
            end
        end
    end

    // Reading status and writing a code share the shift register; the
    // controller must not strobe while a status word sits there.
    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_q <= `LSMC_CFG_RESET; // [RULE_22]
            cfg_wr_q <= 1'b0;
        end else begin
            cfg_wr_q <= strobe_ok && in_special;
            if (strobe_ok && in_special) begin
                cfg_q <= shift_d; // [RULE_19] [RULE_20] [RULE_21]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossings. A stopped serial clock can leave a late latch write
    // waiting in its crossing until the next serial edge.
    assign out_if.data = out_latch_q;
    assign out_if.load = out_wr_q;
    assign cfg_if.data = cfg_q;
    assign cfg_if.load = cfg_wr_q;
    assign sts_if.data = status_code;
    assign sts_if.load = 1'b1;

    lsmc_xfer #(.W(SR), .RST(`LSMC_OUT_RESET)) u_out_xfer (
        .src_clk_in(serial_clk_in),
        .dst_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .word_if(out_if),
        .data_out(out_sys)
    );

    lsmc_xfer #(.W(SR), .RST(`LSMC_CFG_RESET)) u_cfg_xfer (
        .src_clk_in(serial_clk_in),
        .dst_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .word_if(cfg_if),
        .data_out(cfg_sys)
    );

    lsmc_xfer #(.W(SR), .RST(`LSMC_ERR_RESET)) u_sts_xfer (
        .src_clk_in(sys_clk_in),
        .dst_clk_in(serial_clk_in),
        .rstn_in(rstn_in),
        .word_if(sts_if),
        .data_out(status_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Level and event synchronisers into the system clock.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            oe_s1_q <= 1'b1;
            oe_s2_q <= 1'b1;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
        end else begin
            oe_s1_q <= output_enable_n_line_in;
            oe_s2_q <= oe_s1_q;
            mode_s1_q <= special_lvl_q;
            mode_s2_q <= mode_s1_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            clr_s1_q <= 1'b0;
            clr_s2_q <= 1'b0;
            clr_s3_q <= 1'b0;
        end else begin
            clr_s1_q <= clr_tgl_q;
            clr_s2_q <= clr_s1_q;
            clr_s3_q <= clr_s2_q;
        end
    end

    assign clr_evt = clr_s2_q != clr_s3_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_s1_q <= '0;
            fault_s2_q <= '0;
        end else begin
            fault_s1_q <= channel_fault_in;
            fault_s2_q <= fault_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error detection. Faults are only trusted after the settle time.
    assign detecting = mode_s2_q && !oe_s2_q; // [RULE_14]

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settle_cnt_q <= '0;
        end else if (!detecting) begin
            settle_cnt_q <= '0;
        end else if (!settled) begin
            settle_cnt_q <= settle_cnt_q + 1'b1;
        end
    end

    assign settled = settle_cnt_q == ($clog2(SETTLE_CYC+1))'(SETTLE_CYC); // [RULE_16]

    // Per channel: a fault found in the clearing cycle still sticks.
    genvar ch;
    generate
        for (ch = 0; ch < CH; ch++) begin : g_err
            always_ff @(posedge sys_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    err_ok_q[ch] <= 1'b1;
                end else begin
                    err_ok_q[ch] <= (clr_evt | err_ok_q[ch])
                        & ~(detecting & settled & out_sys[ch] & fault_s2_q[ch]); // [RULE_25]
                end
            end
            // A channel that is off cannot be checked and reads as zero.
            assign status_code[ch] = err_ok_q[ch] & out_sys[ch]; // [RULE_24]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs in the system clock.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            channel_sink_out <= '0;
        end else begin
            channel_sink_out <= out_sys[CH-1:0] & {CH{~oe_s2_q}}; // [RULE_03] [RULE_09]
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            special_mode_out <= 1'b0;
            error_detect_out <= 1'b0;
        end else begin
            special_mode_out <= mode_s2_q;
            error_detect_out <= detecting;
        end
    end

    // Bit 2 of the code is the mantissa's most significant bit.
    generate
        for (ch = 0; ch < `LSMC_CFG_MANT_W; ch++) begin : g_mant
            assign gain_mantissa_out[`LSMC_CFG_MANT_W-1-ch] =
                cfg_sys[`LSMC_CFG_MANT_LSB+ch]; // [RULE_23]
        end
    endgenerate

    assign current_multiplier_bit_out = cfg_sys[`LSMC_CFG_CM_BIT]; // [RULE_23]
    assign gain_range_bit_out = cfg_sys[`LSMC_CFG_HC_BIT]; // [RULE_23]

endmodule : lsmc_top

// file: tb/lsmc_properties.sv
// Port-level concurrent checks for the serial LED sink mode control block.
`timescale 1ns/1ps
`include "lsmc_regs.svh"
module lsmc_properties #(
    parameter int CH = `LSMC_CH_NUM,
    parameter int SETTLE_CYC = `LSMC_SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_pin_in,
    input wire logic latch_strobe_line_in,
    input wire logic output_enable_n_line_in,
    input wire logic [CH-1:0] channel_fault_in,
    input wire logic serial_out_pin_out,
    input wire logic [CH-1:0] channel_sink_out,
    input wire logic current_multiplier_bit_out,
    input wire logic gain_range_bit_out,
    input wire logic [`LSMC_CFG_MANT_W-1:0] gain_mantissa_out,
    input wire logic special_mode_out,
    input wire logic error_detect_out
);
    logic [3:0] hi_cnt_q;
    logic [4:0] norm_cnt_q;
    ////////////////////////////////////////////////////////////////////////////
    // Only a run of high enables guarantees that no status word replaced the shift data.
    always_ff @(posedge serial_clk_in or negedge rstn_in) begin
        if (!rstn_in) hi_cnt_q <= 4'h0;
        else if (!output_enable_n_line_in) hi_cnt_q <= 4'h0;
        else if (hi_cnt_q != 4'hf) hi_cnt_q <= hi_cnt_q + 4'h1;
    end
    // Configuration crossings may still land shortly after the mode flag drops.
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) norm_cnt_q <= 5'h1f;
        else if (special_mode_out) norm_cnt_q <= 5'h00;
        else if (norm_cnt_q != 5'h1f) norm_cnt_q <= norm_cnt_q + 5'h01;
    end
    sequence pulse_s;
        output_enable_n_line_in ##1 !output_enable_n_line_in ##1 output_enable_n_line_in;
    endsequence
    sequence off_run_s;
        output_enable_n_line_in [*4];
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    shift_pass_a: assert property (
        @(posedge serial_clk_in) disable iff (!rstn_in)
        hi_cnt_q >= 4'h8 |-> serial_out_pin_out == $past(serial_in_pin_in, 8))
        else $error("serial output lost an input bit");
    special_entry_a: assert property (
        @(posedge serial_clk_in) disable iff (!rstn_in)
        pulse_s ##1 latch_strobe_line_in |-> ##[2:16] special_mode_out)
        else $error("special mode not entered");
    normal_entry_a: assert property (
        @(posedge serial_clk_in) disable iff (!rstn_in)
        pulse_s ##1 !latch_strobe_line_in |-> ##[2:16] !special_mode_out)
        else $error("normal mode not entered");
    reset_values_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(rstn_in) |-> {current_multiplier_bit_out, gain_range_bit_out,
        gain_mantissa_out} == 8'hff && channel_sink_out == '0 && !special_mode_out)
        else $error("wrong values after reset");
    sinks_off_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        off_run_s |=> channel_sink_out == '0)
        else $error("sinks on while enable high");
    detect_mode_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        error_detect_out |-> special_mode_out)
        else $error("detection outside special mode");
    detect_cause_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $rose(error_detect_out) |-> !$past(output_enable_n_line_in, 2)
        || !$past(output_enable_n_line_in, 3) || !$past(output_enable_n_line_in, 4))
        else $error("detection started without low enable");
    detect_end_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        off_run_s |=> !error_detect_out)
        else $error("detection kept after enable high");
    cfg_hold_a: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $changed({gain_mantissa_out, gain_range_bit_out, current_multiplier_bit_out})
        |-> special_mode_out || norm_cnt_q < 5'h10)
        else $error("configuration changed in normal mode");
endmodule : lsmc_properties

bind lsmc_top lsmc_properties #(.CH(CH), .SETTLE_CYC(SETTLE_CYC)) lsmc_properties_inst (
    .sys_clk_in, .rstn_in, .serial_clk_in, .serial_in_pin_in, .latch_strobe_line_in,
    .output_enable_n_line_in, .channel_fault_in, .serial_out_pin_out, .channel_sink_out,
    .current_multiplier_bit_out, .gain_range_bit_out, .gain_mantissa_out,
    .special_mode_out, .error_detect_out);

// file: tb/lsmc_ctrl_model.sv
// Behavioural system controller that clocks the serial link edge by edge.
`timescale 1ns/1ps
module lsmc_ctrl_model (
    output logic serial_clk_out,
    output logic serial_data_out,
    output logic strobe_out,
    output logic enable_n_out,
    input wire logic serial_back_in
);
    initial begin
        serial_clk_out = 1'b1;
        serial_data_out = 1'b0;
        strobe_out = 1'b0;
        enable_n_out = 1'b1;
    end
    // The clock idles high between calls; gap stretches it to act as a slow controller.
    task automatic step(input logic d, input logic le, input logic oen, input int gap,
                        output logic so);
        #(2 + gap);
        serial_data_out = d;
        strobe_out = le;
        enable_n_out = oen;
        #28 serial_clk_out = 1'b0;
        #31 so = serial_back_in;
        #1 serial_clk_out = 1'b1;
        // The data line is held only 2 ns after the edge and then inverted, so a late sample sees the wrong bit.
        #2 serial_data_out = ~d;
    endtask : step
endmodule : lsmc_ctrl_model

// file: tb/lsmc_bench.sv
// Self-checking bench for the serial LED sink mode control block.
`timescale 1ns/1ps
`include "lsmc_regs.svh"
module lsmc_bench;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic sclk, serial_in_pin, le, oen, serial_out_pin, sp, ed, cm, gr;
    logic [7:0] fault = 8'h00;
    logic [7:0] sink;
    logic [5:0] mant;
    logic [31:0] rng = 32'h7804;
    int n_fail = 0;
    int total_checks = 0;
    int sh = 0, lat = 0, cfg = 32'hff, stk = 32'hff, lows = 0;
    bit spec = 0, blind = 0;

    always #50 sys_clk_in = ~sys_clk_in;

    lsmc_top #(.SETTLE_CYC(2)) lsmc_top_inst (.sys_clk_in, .rstn_in, .serial_clk_in(sclk),
        .serial_in_pin_in(serial_in_pin), .latch_strobe_line_in(le), .output_enable_n_line_in(oen),
        .channel_fault_in(fault), .serial_out_pin_out(serial_out_pin), .channel_sink_out(sink),
        .current_multiplier_bit_out(cm), .gain_range_bit_out(gr), .gain_mantissa_out(mant),
        .special_mode_out(sp), .error_detect_out(ed));
    lsmc_ctrl_model lsmc_ctrl_model_inst (.serial_clk_out(sclk), .serial_data_out(serial_in_pin),
        .strobe_out(le), .enable_n_out(oen), .serial_back_in(serial_out_pin));
    ////////////////////////////////////////////////////////////////////////////
    function automatic bit rb();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[0];
    endfunction : rb
    function automatic logic [7:0] cfg_exp();
        logic [7:0] e;
        e[1:0] = cfg[1:0];
        for (int j = 0; j < 6; j++) e[2 + j] = cfg[7 - j];
        return e;
    endfunction : cfg_exp
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    // Reference model of one serial edge; output is not compared while status loads.
    task automatic tick(input logic d, input logic l, input logic o);
        logic so;
        bit skip;
        skip = spec && !o && lows >= 3;
        // A 64 ns serial period with no stretch keeps the link at its nominal rate.
        lsmc_ctrl_model_inst.step(d, l, o, 0, so);
        if (!skip) check("serial out", 8'(sh >> 7), {7'h0, so});
        if (spec && !o && lows >= 2) sh = lat & stk;
        else sh = ((sh << 1) | d) & 32'hff;
        lows = o ? 0 : lows + 1;
        if (l && !blind && spec) cfg = sh;
        if (l && !blind && !spec) lat = sh;
    endtask : tick
    task automatic send(input logic [7:0] v);
        for (int i = 7; i > 0; i--) tick(v[i], 1'b0, 1'b1);
        tick(v[0], 1'b1, 1'b1);
    endtask : send
    task automatic hold_low();
        repeat (10) tick(rb(), 1'b0, 1'b0);
        @(negedge sys_clk_in);
        check("sinks", 8'(lat), sink);
    endtask : hold_low
    task automatic cfg_check();
        repeat (10) tick(rb(), 1'b0, 1'b1);
        @(negedge sys_clk_in);
        check("config", cfg_exp(), {mant, gr, cm});
        check("special", 8'(spec), {7'h0, sp});
    endtask : cfg_check
    task automatic switch_mode(input bit sel);
        tick(rb(), 1'b0, 1'b1);
        tick(rb(), 1'b0, 1'b0);
        blind = 1;
        repeat (3) tick(rb(), sel, 1'b1);
        blind = 0;
        spec = sel;
        if (!sel) stk = 32'hff;
    endtask : switch_mode
    task automatic read_status(input logic [7:0] f);
        @(posedge sys_clk_in);
        #2 fault = f;
        stk = stk & ~(f & lat);
        repeat (20) tick(rb(), 1'b0, 1'b0);
        @(negedge sys_clk_in);
        check("sinks", 8'(lat), sink);
        check("detect", 8'h01, {7'h0, ed});
        repeat (8) tick(rb(), 1'b0, 1'b1);
    endtask : read_status
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge sys_clk_in);
        #2 rstn_in = 1'b1;
        cfg_check();
        repeat (3) begin
            send(rng[15:8]);
            hold_low();
        end
        switch_mode(1'b1);
        cfg_check();
        send(rng[15:8]);
        cfg_check();
        read_status(rng[7:0]);
        read_status(8'h00);
        // Configuration goes in after the readout so no status word overwrites it.
        send(rng[15:8]);
        cfg_check();
        switch_mode(1'b0);
        send(rng[15:8]);
        hold_low();
        cfg_check();
        switch_mode(1'b1);
        read_status(8'h00);
        repeat (16) tick(rb(), 1'b0, 1'b1);
        print_verdict();
    end
    // The sequence needs about 250 serial edges, some 17 us; 300 us is a hang.
    initial begin
        #300000;
        n_fail++;
        print_verdict();
    end
endmodule : lsmc_bench
